// *** rivag_consts.svh ***
// constants for the reset and interrupt vector address generator
// assumes word addressed program memory, 16-bit program counter
`ifndef RIVAG_CONSTS_SVH
`define RIVAG_CONSTS_SVH

// register byte offsets on the apb
`define RIVAG_OFF_CTRL     12'h000
`define RIVAG_OFF_STATUS   12'h004
`define RIVAG_OFF_CLEAR    12'h008
`define RIVAG_OFF_ENABLE   12'h00c
`define RIVAG_OFF_INFO     12'h010

// mcu_control_reg fields
`define RIVAG_BIT_UNLOCK   0
`define RIVAG_BIT_VSEL     1

// status, clear and enable fields
`define RIVAG_EVT_SWITCH   0
`define RIVAG_EVT_EXPIRE   1
`define RIVAG_EVT_W        2

// vector layout, word addresses
`define RIVAG_RESET_VEC    16'h0000
`define RIVAG_VEC_FIRST    16'h0002
`define RIVAG_VEC_STEP     16'h0002
`define RIVAG_NUM_SRC      24
`define RIVAG_RESERVED_IDX 5'h15
`define RIVAG_PC_CD_FIRST  5'h16
`define RIVAG_HAS_PC_CD    1'b1

// fuse polarity: stored zero means programmed
`define RIVAG_FUSE_PROG    1'b0

// unlock window length in core clocks
`define RIVAG_UNLOCK_CYC   3'h4

`endif

// *** rivag_core_model.sv ***
// core fetch model: accepts presented vectors after a set delay, retires
// one instruction every fourth cycle
// assumes the generator's vector handshake, all on clock_i
`timescale 1ns/10ps

module rivag_core_model (
  input  wire logic        clock_i,
  input  wire logic        rst_b_i,
  input  wire logic        vec_req_i,
  input  wire logic [15:0] vec_addr_i,
  input  wire logic [1:0]  wait_i,
  output logic             ack_o,
  output logic             retire_o,
  output logic [15:0]      last_addr_o,
  output logic [7:0]       taken_o
);
  logic [1:0] cnt;
  logic [1:0] rcnt;

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      ack_o       <= 1'b0;
      cnt         <= 2'h0;
      rcnt        <= 2'h0;
      retire_o    <= 1'b0;
      last_addr_o <= 16'h0000;
      taken_o     <= 8'h00;
    end else begin
      rcnt     <= rcnt + 2'h1;
      retire_o <= (rcnt == 2'h3);
      if (ack_o) begin
        ack_o <= 1'b0;
        // address taken at the accepting edge only
        if (vec_req_i) begin
          last_addr_o <= vec_addr_i;
          taken_o     <= taken_o + 8'h01;
        end
      end else if (vec_req_i) begin
        // slow or prompt acceptance, set by the bench
        if (cnt == wait_i) begin
          ack_o <= 1'b1;
          cnt   <= 2'h0;
        end else begin
          cnt <= cnt + 2'h1;
        end
      end else begin
        cnt <= 2'h0;
      end
    end
  end
endmodule

// *** rivag_pkg.sv ***
// types for the reset and interrupt vector address generator
// assumes rivag_consts.svh supplies the numeric constants
package rivag_pkg;

  // source index: vector number minus two
  typedef enum logic [4:0] {
    SRC_EXT_IRQ_ZERO      = 5'h00,
    SRC_PIN_CHANGE_IRQ_A  = 5'h01,
    SRC_PIN_CHANGE_IRQ_B  = 5'h02,
    SRC_T2_COMPARE        = 5'h03,
    SRC_T2_OVERFLOW       = 5'h04,
    SRC_T1_CAPTURE        = 5'h05,
    SRC_T1_COMPARE_A      = 5'h06,
    SRC_T1_COMPARE_B      = 5'h07,
    SRC_T1_OVERFLOW       = 5'h08,
    SRC_T0_COMPARE        = 5'h09,
    SRC_T0_OVERFLOW       = 5'h0a,
    SRC_SPI_XFER_DONE     = 5'h0b,
    SRC_UART_RX_DONE      = 5'h0c,
    SRC_UART_TX_BUF_EMPTY = 5'h0d,
    SRC_UART_TX_DONE      = 5'h0e,
    SRC_USU_START         = 5'h0f,
    SRC_USU_OVERFLOW      = 5'h10,
    SRC_ANALOG_CMP        = 5'h11,
    SRC_CONV_DONE         = 5'h12,
    SRC_NV_DATA_READY     = 5'h13,
    SRC_SELF_PROG_READY   = 5'h14,
    SRC_RESERVED          = 5'h15,
    SRC_PIN_CHANGE_IRQ_C  = 5'h16,
    SRC_PIN_CHANGE_IRQ_D  = 5'h17
  } rivag_src_t;

  // vector-change sequence, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_OPEN = 3'b010,
    ST_WAIT = 3'b100
  } rivag_state_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [4:0]  src;
  } rivag_vec_t;

endpackage

// *** rivag_vector_gen.sv ***
// reset and interrupt vector address generator with apb control registers
// assumes request lines and core handshakes run on clock_i; fuse inputs are
// static straps from outside and are synchronised before use
//
// Summary of operation
// [RULE_01] all reset causes share one reset vector, 0x0000 with fuse unprogrammed
// [RULE_02] ext irq zero at 0x0002, pin change a 0x0004, b 0x0006
// [RULE_03] timer vectors two words apart from 0x0008 through 0x0016
// [RULE_04] serial transfer done at 0x0018, then uart vectors through 0x001e
// [RULE_05] serial unit, comparator, converter, store vectors 0x0020 through 0x002a
// [RULE_06] slot 0x002c never requested; pin change c, d at 0x002e, 0x0030
// [RULE_07] select bit set adds boot section start to every interrupt vector
// [RULE_08] programmed fuse puts reset at boot address regardless of select bit
// [RULE_09] table starts at 0x0002, or boot address plus 0x0002 when selected
// [RULE_10] fuse value one is unprogrammed, zero is programmed
// [RULE_11] software may place code in vector slots that are never used
// [RULE_12] select bit is control bit 1, unlock bit is bit 0
// [RULE_13] unlock clears after four cycles or on select write; select changes only then
// [RULE_14] requests blocked while unlocked and until one instruction after select write
// [RULE_15] among pending requests the lowest vector address wins
// [RULE_16] vector registered and stable at accept; reset address applied at release
//
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`include "rivag_consts.svh"

module rivag_vector_gen (
  input  wire logic                      clock_i,
  input  wire logic                      rst_b_i,
  input  wire logic                      psel_i,
  input  wire logic                      penable_i,
  input  wire logic                      pwrite_i,
  input  wire logic [11:0]               paddr_i,
  input  wire logic [31:0]               pwdata_i,
  output logic                           pready_o,
  output logic                           pslverr_o,
  output logic [31:0]                    prdata_o,
  input  wire logic                      boot_reset_fuse_i,
  input  wire logic [15:0]               boot_addr_i,
  input  wire logic [`RIVAG_NUM_SRC-1:0] irq_req_i,
  input  wire logic                      core_ack_i,
  input  wire logic                      core_retire_i,
  output logic                           vec_req_o,
  output logic [15:0]                    vec_addr_o,
  output logic                           reset_load_o,
  output logic [15:0]                    reset_addr_o,
  output logic                           irq_o
);

  function automatic logic [15:0] vec_offset(input logic [4:0] idx);
    vec_offset = `RIVAG_VEC_FIRST + 16'({idx, 1'b0}); // see [RULE_02] [RULE_03]
  endfunction

  // lowest index wins, which is also the lowest address
  function automatic logic [5:0] pick_lowest(input logic [`RIVAG_NUM_SRC-1:0] req);
    logic [5:0] res;
    res = 6'h00;
    for (int i = `RIVAG_NUM_SRC - 1; i >= 0; i--) begin
      if (req[i]) begin
        res = {1'b1, 5'(i)}; // see [RULE_15]
      end
    end
    pick_lowest = res;
  endfunction

  // fuse straps: two flops, no reset, so they are settled when reset lifts
  logic        fuse_meta;
  logic        fuse_q;
  logic [15:0] boot_meta;
  logic [15:0] boot_q;

  always_ff @(posedge clock_i) begin
    fuse_meta <= boot_reset_fuse_i;
    fuse_q    <= fuse_meta;
    boot_meta <= boot_addr_i;
    boot_q    <= boot_meta;
  end

  // source presence mask
  logic [`RIVAG_NUM_SRC-1:0] src_present;

  genvar g;
  generate
    for (g = 0; g < `RIVAG_NUM_SRC; g++) begin : g_mask
      if (g == `RIVAG_RESERVED_IDX) begin : g_res
        assign src_present[g] = 1'b0; // see [RULE_06]
      end else if (g >= `RIVAG_PC_CD_FIRST) begin : g_pc
        assign src_present[g] = `RIVAG_HAS_PC_CD; // see [RULE_06]
      end else begin : g_std
        assign src_present[g] = 1'b1;
      end
    end
  endgenerate

  // apb decode
  logic apb_access;
  logic apb_commit;
  logic wr_ctrl;
  logic wr_clear;
  logic wr_enable;
  logic addr_ok;

  always_comb begin
    apb_access = psel_i && penable_i;
    apb_commit = apb_access && pready_o;
    addr_ok    = (paddr_i == `RIVAG_OFF_CTRL) || (paddr_i == `RIVAG_OFF_STATUS) ||
                 (paddr_i == `RIVAG_OFF_CLEAR) || (paddr_i == `RIVAG_OFF_ENABLE) ||
                 (paddr_i == `RIVAG_OFF_INFO);
    wr_ctrl    = apb_commit && pwrite_i && (paddr_i == `RIVAG_OFF_CTRL);
    wr_clear   = apb_commit && pwrite_i && (paddr_i == `RIVAG_OFF_CLEAR);
    wr_enable  = apb_commit && pwrite_i && (paddr_i == `RIVAG_OFF_ENABLE);
  end

  // vector-change sequence
  rivag_pkg::rivag_state_t state;
  rivag_pkg::rivag_state_t next_state;
  logic [2:0]              open_cnt;
  logic [2:0]              next_open_cnt;
  logic                    vsel;
  logic                    next_vsel;
  logic                    evt_switch;
  logic                    evt_expire;
  logic                    ctrl_unlock;
  logic                    block;

  always_comb begin
    next_state    = state;
    next_open_cnt = open_cnt + 3'h1;
    next_vsel     = vsel;
    evt_switch    = 1'b0;
    evt_expire    = 1'b0;
    case (state)
      rivag_pkg::ST_IDLE: begin
        if (wr_ctrl && pwdata_i[`RIVAG_BIT_UNLOCK]) begin
          next_state    = rivag_pkg::ST_OPEN;
          next_open_cnt = 3'h0;
        end
      end
      rivag_pkg::ST_OPEN: begin
        if (wr_ctrl && pwdata_i[`RIVAG_BIT_UNLOCK]) begin
          next_open_cnt = 3'h0;
        end else if (wr_ctrl) begin
          next_vsel  = pwdata_i[`RIVAG_BIT_VSEL]; // see [RULE_13]
          next_state = rivag_pkg::ST_WAIT;
          evt_switch = 1'b1;
        end else if (open_cnt == `RIVAG_UNLOCK_CYC - 3'h1) begin
          next_state = rivag_pkg::ST_IDLE; // see [RULE_13]
          evt_expire = 1'b1;
        end
      end
      rivag_pkg::ST_WAIT: begin
        // the instruction after the select write must retire first
        if (core_retire_i) begin
          next_state = rivag_pkg::ST_IDLE; // see [RULE_14]
        end
      end
      default: begin
        next_state = rivag_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      state    <= rivag_pkg::ST_IDLE;
      open_cnt <= 3'h0;
      vsel     <= 1'b0;
    end else begin
      state    <= next_state;
      open_cnt <= next_open_cnt;
      vsel     <= next_vsel;
    end
  end

  always_comb begin
    ctrl_unlock = (state == rivag_pkg::ST_OPEN);
    block       = (state != rivag_pkg::ST_IDLE); // see [RULE_14]
  end

  // sticky events, enable and irq line; set beats clear
  logic [`RIVAG_EVT_W-1:0] status;
  logic [`RIVAG_EVT_W-1:0] next_status;
  logic [`RIVAG_EVT_W-1:0] enable;
  logic [`RIVAG_EVT_W-1:0] next_enable;
  logic [`RIVAG_EVT_W-1:0] evt_set;

  always_comb begin
    evt_set                    = '0;
    evt_set[`RIVAG_EVT_SWITCH] = evt_switch;
    evt_set[`RIVAG_EVT_EXPIRE] = evt_expire;
    next_status                = status;
    if (wr_clear) begin
      next_status = status & ~pwdata_i[`RIVAG_EVT_W-1:0];
    end
    next_status = next_status | evt_set;
    next_enable = wr_enable ? pwdata_i[`RIVAG_EVT_W-1:0] : enable;
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      status <= '0;
      enable <= '0;
      irq_o  <= 1'b0;
    end else begin
      status <= next_status;
      enable <= next_enable;
      irq_o  <= |(next_status & next_enable);
    end
  end

  // apb answer: one wait state, data registered with pready
  logic        next_pready;
  logic        next_pslverr;
  logic [31:0] next_prdata;

  always_comb begin
    next_pready  = apb_access && !pready_o;
    next_pslverr = next_pready && !addr_ok;
    next_prdata  = 32'h0000_0000;
    if (next_pready && !pwrite_i) begin
      case (paddr_i)
        `RIVAG_OFF_CTRL: begin
          next_prdata[`RIVAG_BIT_VSEL]   = vsel; // see [RULE_12]
          next_prdata[`RIVAG_BIT_UNLOCK] = ctrl_unlock; // see [RULE_12]
        end
        `RIVAG_OFF_STATUS: begin
          next_prdata[`RIVAG_EVT_W-1:0] = status;
        end
        `RIVAG_OFF_ENABLE: begin
          next_prdata[`RIVAG_EVT_W-1:0] = enable;
        end
        `RIVAG_OFF_INFO: begin
          // table base is the first interrupt slot, not the reset slot
          next_prdata = {reset_addr_o, (vsel ? boot_q : `RIVAG_RESET_VEC) + `RIVAG_VEC_FIRST}; // see [RULE_09]
        end
        default: begin
          next_prdata = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end else begin
      pready_o  <= next_pready;
      pslverr_o <= next_pslverr;
      prdata_o  <= next_prdata;
    end
  end

  // reset vector: presented once after release
  logic        load_done;
  logic [15:0] next_reset_addr;

  always_comb begin
    // see [RULE_01] [RULE_08] [RULE_10]
    next_reset_addr = (fuse_q == `RIVAG_FUSE_PROG) ? boot_q : `RIVAG_RESET_VEC;
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      load_done    <= 1'b0;
      reset_load_o <= 1'b0;
      reset_addr_o <= `RIVAG_RESET_VEC;
    end else begin
      load_done    <= 1'b1;
      reset_load_o <= !load_done; // see [RULE_16]
      reset_addr_o <= next_reset_addr;
    end
  end

  // interrupt vector request toward the core
  logic [5:0]        pick;
  logic [15:0]       table_base;
  rivag_pkg::rivag_vec_t vec_q;
  rivag_pkg::rivag_vec_t next_vec;
  logic              next_req;

  always_comb begin
    pick       = pick_lowest(irq_req_i & src_present);
    table_base = vsel ? boot_q : `RIVAG_RESET_VEC; // see [RULE_07] [RULE_09]
    next_vec   = vec_q;
    next_req   = vec_req_o;
    if (block || (vec_req_o && core_ack_i)) begin
      next_req = 1'b0;
    end else if (!vec_req_o && pick[5]) begin
      next_req      = 1'b1;
      next_vec.src  = pick[4:0];
      next_vec.addr = table_base + vec_offset(pick[4:0]); // see [RULE_04] [RULE_05]
    end
  end

  // address frozen while the request stands so the core sees it stable
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      vec_req_o <= 1'b0;
      vec_q     <= '0;
    end else begin
      vec_req_o <= next_req;
      vec_q     <= next_vec; // see [RULE_16]
    end
  end

  assign vec_addr_o = vec_q.addr;

  default clocking dc @(posedge clock_i);
  endclocking
  default disable iff (!rst_b_i);

  sequence s_unlock_set;
    !ctrl_unlock ##1 ctrl_unlock;
  endsequence

  sequence s_window_gone;
    ##[1:4] !ctrl_unlock;
  endsequence

  reset_vec_load_a: assert property ($rose(rst_b_i) |=> reset_load_o ##1 !reset_load_o) // see [RULE_16]
    else $error("reset load pulse missing");
  reset_addr_val_a: assert property (reset_load_o |-> reset_addr_o ==
    ((fuse_q == 1'b0) ? boot_q : 16'h0000)) // see [RULE_08]
    else $error("reset address wrong");
  unlock_window_a: assert property (s_unlock_set |-> s_window_gone) // see [RULE_13]
    else $error("unlock bit held past four cycles");
  select_guard_a: assert property (!$stable(vsel) |-> $past(ctrl_unlock)) // see [RULE_13]
    else $error("select changed outside window");
  block_req_a: assert property (block |=> !vec_req_o) // see [RULE_14]
    else $error("request raised while blocked");
  lowest_first_a: assert property ($rose(vec_req_o) |-> vec_q.src == $past(pick[4:0])) // see [RULE_15]
    else $error("not lowest pending source");
  vec_stable_a: assert property (vec_req_o && !core_ack_i |=> !vec_req_o || $stable(vec_addr_o)) // see [RULE_16]
    else $error("vector moved before accept");
  vec_addr_a: assert property (vec_req_o |-> vec_addr_o ==
    (vsel ? boot_q : 16'h0000) + 16'h0002 + 16'({vec_q.src, 1'b0})) // see [RULE_07]
    else $error("vector address wrong");
  reserved_slot_a: assert property (vec_req_o |-> vec_q.src != 5'h15) // see [RULE_06]
    else $error("reserved slot requested");
  fixed_slots_a: assert property (vec_req_o && !vsel |->
    (vec_q.src != 5'h0a || vec_addr_o == 16'h0016) &&
    (vec_q.src != 5'h0e || vec_addr_o == 16'h001e) &&
    (vec_q.src != 5'h14 || vec_addr_o == 16'h002a)) // see [RULE_03]
    else $error("fixed slot address wrong");
  irq_line_a: assert property (irq_o == |(status & enable))
    else $error("irq line disagrees with status");

endmodule

// *** testbench.sv ***
// self-checking bench for the vector address generator
// assumes an apb master here and the core model on the vector side
`timescale 1ns/10ps
`include "rivag_consts.svh"

module testbench;
  localparam logic [15:0] BOOT = 16'h3800;
  logic        clock_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic        fuse    = 1'b1;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0;
  logic [23:0] irq_req = 24'h0;
  logic [1:0]  wait_c  = 2'h0;
  logic        pready, pslverr, vreq, vack, retire, rload, irq, serr;
  logic [31:0] prdata, rd;
  logic [15:0] vaddr, raddr, last;
  logic [7:0]  taken, t0;
  int          err_total = 0;
  int          checks    = 0;

  always #4 clock_i = ~clock_i;

  rivag_vector_gen DUT (.clock_i(clock_i), .rst_b_i(rst_b_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .pready_o(pready), .pslverr_o(pslverr), .prdata_o(prdata),
    .boot_reset_fuse_i(fuse), .boot_addr_i(BOOT), .irq_req_i(irq_req),
    .core_ack_i(vack), .core_retire_i(retire), .vec_req_o(vreq), .vec_addr_o(vaddr),
    .reset_load_o(rload), .reset_addr_o(raddr), .irq_o(irq));

  rivag_core_model core (.clock_i(clock_i), .rst_b_i(rst_b_i), .vec_req_i(vreq),
    .vec_addr_i(vaddr), .wait_i(wait_c), .ack_o(vack), .retire_o(retire),
    .last_addr_o(last), .taken_o(taken));

  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task wrap_up;
    $display("comparisons %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // request stays up after the answer so a following transfer runs back to back
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (pready !== 1'b1);
    rd   = prdata;
    serr = pslverr;
    chk("apb wait", 32'(n), 32'h2);
  endtask

  task idle;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clock_i);
  endtask

  task take(input int b, input logic [15:0] exp);
    int n;
    t0 = taken;
    n = 0;
    @(posedge clock_i);
    while (vreq !== 1'b1 && n < 50) begin
      @(posedge clock_i);
      n++;
    end
    irq_req[b] <= 1'b0;
    while (taken === t0 && n < 100) begin
      @(posedge clock_i);
      n++;
    end
    chk("vector", {16'h0, last}, {16'h0, exp});
  endtask

  task boot(input logic [15:0] exp);
    int n;
    rst_b_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    rst_b_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (rload !== 1'b1 && n < 10);
    chk("reset addr", {16'h0, raddr}, {16'h0, exp});
  endtask

  initial begin
    #80000;
    err_total++;
    wrap_up();
  end

  initial begin
    boot(16'h0000);
    apb(1'b0, `RIVAG_OFF_INFO, 32'h0);
    chk("table base", rd, 32'h0000_0002);
    idle();
    for (int i = 0; i < 24; i++) begin
      if (i != 21) begin
        wait_c     <= 2'(i);
        irq_req[i] <= 1'b1;
        take(i, 16'h0002 + 16'(2 * i));
      end
    end
    $display("fixed slots done");
    t0 = taken;
    irq_req[21] <= 1'b1;
    repeat (20) @(posedge clock_i);
    chk("reserved slot", {24'h0, taken}, {24'h0, t0});
    irq_req <= 24'h00000a;
    take(1, 16'h0004);
    take(3, 16'h0008);
    $display("reserved and priority done");
    apb(1'b1, `RIVAG_OFF_CTRL, 32'h1);
    irq_req[0] <= 1'b1;
    apb(1'b1, `RIVAG_OFF_CTRL, 32'h2);
    chk("held off", {31'h0, vreq}, 32'h0);
    idle();
    take(0, BOOT + 16'h0002);
    apb(1'b0, `RIVAG_OFF_CTRL, 32'h0);
    chk("control", rd, 32'h2);
    apb(1'b0, `RIVAG_OFF_STATUS, 32'h0);
    chk("status", rd, 32'h1);
    apb(1'b0, `RIVAG_OFF_INFO, 32'h0);
    chk("table base", rd, {16'h0, BOOT + 16'h0002});
    apb(1'b1, `RIVAG_OFF_CTRL, 32'h1);
    // read inside the open window: unlock still shows
    apb(1'b0, `RIVAG_OFF_CTRL, 32'h0);
    chk("control open", rd, 32'h3);
    idle();
    repeat (6) @(posedge clock_i);
    apb(1'b1, `RIVAG_OFF_CTRL, 32'h0);
    apb(1'b0, `RIVAG_OFF_CTRL, 32'h0);
    chk("control", rd, 32'h2);
    apb(1'b0, `RIVAG_OFF_STATUS, 32'h0);
    chk("status", rd, 32'h3);
    $display("vector move done");
    apb(1'b1, `RIVAG_OFF_ENABLE, 32'h2);
    idle();
    repeat (2) @(posedge clock_i);
    chk("irq", {31'h0, irq}, 32'h1);
    apb(1'b1, `RIVAG_OFF_ENABLE, 32'h0);
    idle();
    repeat (2) @(posedge clock_i);
    chk("irq", {31'h0, irq}, 32'h0);
    apb(1'b1, `RIVAG_OFF_ENABLE, 32'h3);
    apb(1'b1, `RIVAG_OFF_CLEAR, 32'h3);
    apb(1'b0, `RIVAG_OFF_ENABLE, 32'h0);
    chk("enable", rd, 32'h3);
    apb(1'b0, `RIVAG_OFF_STATUS, 32'h0);
    chk("status", rd, 32'h0);
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped err", {31'h0, serr}, 32'h1);
    chk("unmapped data", rd, 32'h0);
    idle();
    chk("irq", {31'h0, irq}, 32'h0);
    $display("interrupt and bus done");
    fuse <= 1'b0;
    boot(BOOT);
    apb(1'b0, `RIVAG_OFF_INFO, 32'h0);
    chk("info", rd, {BOOT, 16'h0002});
    idle();
    $display("boot fuse done");
    wrap_up();
  end
endmodule
